//--- rtl/atc_regs.sv
// Threshold, identity, scratch and trim register bank with APB slave
`timescale 1ns/1ps
module atc_regs #(
	parameter logic [63:0] BATCH_ID = 64'h0123_4567_89ab_cdef, // Arbitrary
	parameter logic [15:0] SERIAL_ID = 16'h5a3c // Arbitrary
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Raw conversion results
	input wire atc_pkg::atc_sample_t cell_raw,
	input wire atc_pkg::atc_sample_t aux0_raw,
	input wire atc_pkg::atc_sample_t aux1_raw,
	input wire atc_pkg::atc_sample_t aux7_raw,
	// Corrected conversion results
	output atc_pkg::atc_sample_t cell_trimmed,
	output atc_pkg::atc_sample_t aux0_trimmed,
	output atc_pkg::atc_sample_t aux1_trimmed,
	// Channel 7 limit verdict, one pulse per sample
	output atc_pkg::atc_limit_evt_t aux7_verdict,
	// Interrupt request, level
	output logic irq
);
	atc_pkg::atc_state_t s_reg;
	atc_pkg::atc_state_t s_next;
	logic [7:0] idx;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic setup;
	logic wr_en;
	logic [7:0] wb;
	logic [7:0] off;

	// Byte k of a 64-bit value, k = 0 being the most significant
	function automatic logic [7:0] byte_of(input logic [63:0] v,
		input logic [2:0] k);
		byte_of = v[8 * (7 - int'(k)) +: 8];
	endfunction

	// True when an index falls inside a run of byte locations
	function automatic logic in_run(input logic [7:0] i,
		input logic [7:0] base, input logic [7:0] len);
		in_run = (i >= base) && (i < 8'(base + len));
	endfunction

	// Cell channel gain and offset correction
	atc_trim #(
		.GAIN_W(atc_pkg::CELL_TRIM_W),
		.OFF_W(atc_pkg::CELL_TRIM_W)
	) u_cell_trim (
		.mclk(mclk),
		.rst(rst),
		.gain(s_reg.cell_gain),
		.offset(s_reg.cell_off),
		.raw(cell_raw),
		.trimmed(cell_trimmed)
	);

	// Auxiliary channel 0 offset correction, unity gain
	atc_trim #(
		.GAIN_W(atc_pkg::CELL_TRIM_W),
		.OFF_W(atc_pkg::AUX_OFF_W)
	) u_aux0_trim (
		.mclk(mclk),
		.rst(rst),
		.gain(8'h00),
		.offset(s_reg.aux0_off),
		.raw(aux0_raw),
		.trimmed(aux0_trimmed)
	);

	// Auxiliary channel 1 offset correction, unity gain
	atc_trim #(
		.GAIN_W(atc_pkg::CELL_TRIM_W),
		.OFF_W(atc_pkg::AUX_OFF_W)
	) u_aux1_trim (
		.mclk(mclk),
		.rst(rst),
		.gain(8'h00),
		.offset(s_reg.aux1_off),
		.raw(aux1_raw),
		.trimmed(aux1_trimmed)
	);

	// Channel 7 window check against the stored limits
	atc_limit_cmp u_aux7_cmp (
		.mclk(mclk),
		.rst(rst),
		.low_limit(s_reg.low_limit),
		.high_limit(s_reg.high_limit),
		.sample(aux7_raw),
		.verdict(aux7_verdict)
	);

	// Bus phase decode
	assign idx = paddr[9:2];
	assign setup = psel && !penable;
	assign wb = pwdata[7:0];

	// Read decode: one byte location per word, upper lanes zero
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		off = 8'h00;
		if (paddr[11:10] != 2'h0) begin
			rd_hit = 1'b0;
		end else if (idx == atc_pkg::IDX_LOW_LIMIT) begin
			rd_byte = s_reg.low_limit[13:6];
		end else if (idx == 8'(atc_pkg::IDX_LOW_LIMIT + 8'h01)) begin
			rd_byte = {s_reg.low_limit[5:0], 2'b00};
		end else if (idx == atc_pkg::IDX_HIGH_LIMIT) begin
			rd_byte = s_reg.high_limit[13:6];
		end else if (idx == 8'(atc_pkg::IDX_HIGH_LIMIT + 8'h01)) begin
			rd_byte = {s_reg.high_limit[5:0], 2'b00};
		end else if (in_run(idx, atc_pkg::IDX_BATCH_ID,
			atc_pkg::BATCH_BYTES)) begin
			off = 8'(idx - atc_pkg::IDX_BATCH_ID);
			rd_byte = byte_of(BATCH_ID, off[2:0]);
		end else if (idx == atc_pkg::IDX_SERIAL_ID) begin
			rd_byte = SERIAL_ID[15:8];
		end else if (idx == 8'(atc_pkg::IDX_SERIAL_ID + 8'h01)) begin
			rd_byte = SERIAL_ID[7:0];
		end else if (in_run(idx, atc_pkg::IDX_SCRATCH,
			atc_pkg::SCRATCH_BYTES)) begin
			off = 8'(idx - atc_pkg::IDX_SCRATCH);
			rd_byte = byte_of(s_reg.scratch, off[2:0]);
		end else if (idx == atc_pkg::IDX_CELL_OFF) begin
			rd_byte = s_reg.cell_off;
		end else if (idx == atc_pkg::IDX_CELL_GAIN) begin
			rd_byte = s_reg.cell_gain;
		end else if (idx == atc_pkg::IDX_AUX0_OFF) begin
			rd_byte = {6'h00, s_reg.aux0_off[9:8]};
		end else if (idx == 8'(atc_pkg::IDX_AUX0_OFF + 8'h01)) begin
			rd_byte = s_reg.aux0_off[7:0];
		end else if (idx == atc_pkg::IDX_AUX1_OFF) begin
			rd_byte = {6'h00, s_reg.aux1_off[9:8]};
		end else if (idx == 8'(atc_pkg::IDX_AUX1_OFF + 8'h01)) begin
			rd_byte = s_reg.aux1_off[7:0];
		end else if (idx == atc_pkg::IDX_IRQ_STATUS) begin
			rd_byte = {6'h00, s_reg.status};
		end else if (idx == atc_pkg::IDX_IRQ_MASK) begin
			rd_byte = {6'h00, s_reg.mask};
		end else if (idx == atc_pkg::IDX_AUX7_LEVEL) begin
			rd_byte = {6'h00, s_reg.level};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Write strobe: the edge that completes the access phase
	assign wr_en = psel && penable && s_reg.pready && pwrite && rd_hit;

	// Next state: bus answer, register writes, event capture
	always_comb begin
		s_next = s_reg;
		// Zero-wait answer prepared during the setup cycle
		s_next.pready = setup;
		s_next.pslverr = setup && !rd_hit;
		if (setup) begin
			s_next.prdata = {24'h000000, rd_byte};
		end
		// Writes land on one byte; reserved bits are dropped
		if (wr_en) begin
			if (idx == atc_pkg::IDX_LOW_LIMIT) begin
				s_next.low_limit[13:6] = wb;
			end else if (idx == 8'(atc_pkg::IDX_LOW_LIMIT + 8'h01)) begin
				s_next.low_limit[5:0] = wb[7:2];
			end else if (idx == atc_pkg::IDX_HIGH_LIMIT) begin
				s_next.high_limit[13:6] = wb;
			end else if (idx == 8'(atc_pkg::IDX_HIGH_LIMIT + 8'h01)) begin
				s_next.high_limit[5:0] = wb[7:2];
			end else if (in_run(idx, atc_pkg::IDX_SCRATCH,
				atc_pkg::SCRATCH_BYTES)) begin
				for (int k = 0; k < 8; k++) begin
					if (idx == 8'(atc_pkg::IDX_SCRATCH + 8'(k))) begin
						s_next.scratch[8 * (7 - k) +: 8] = wb;
					end
				end
			end else if (idx == atc_pkg::IDX_CELL_OFF) begin
				s_next.cell_off = wb;
			end else if (idx == atc_pkg::IDX_CELL_GAIN) begin
				s_next.cell_gain = wb;
			end else if (idx == atc_pkg::IDX_AUX0_OFF) begin
				s_next.aux0_off[9:8] = wb[1:0];
			end else if (idx == 8'(atc_pkg::IDX_AUX0_OFF + 8'h01)) begin
				s_next.aux0_off[7:0] = wb;
			end else if (idx == atc_pkg::IDX_AUX1_OFF) begin
				s_next.aux1_off[9:8] = wb[1:0];
			end else if (idx == 8'(atc_pkg::IDX_AUX1_OFF + 8'h01)) begin
				s_next.aux1_off[7:0] = wb;
			end else if (idx == atc_pkg::IDX_IRQ_STATUS) begin
				s_next.status = s_reg.status & ~wb[1:0]; // Write one to clear
			end else if (idx == atc_pkg::IDX_IRQ_MASK) begin
				s_next.mask = wb[1:0];
			end
		end
		// Verdict of the latest channel 7 sample, and sticky events
		if (aux7_verdict.valid) begin
			s_next.level[atc_pkg::EVT_OVER] = aux7_verdict.over;
			s_next.level[atc_pkg::EVT_UNDER] = aux7_verdict.under;
		end
		// Setting after the clear lets a same-cycle event win
		if (aux7_verdict.over) begin
			s_next.status[atc_pkg::EVT_OVER] = 1'b1;
		end
		if (aux7_verdict.under) begin
			s_next.status[atc_pkg::EVT_UNDER] = 1'b1;
		end
		s_next.irq = |(s_next.status & s_next.mask);
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_reg.low_limit <= atc_pkg::LOW_LIMIT_RST;
			s_reg.high_limit <= atc_pkg::HIGH_LIMIT_RST;
			s_reg.scratch <= atc_pkg::SCRATCH_RST;
			s_reg.cell_off <= atc_pkg::CELL_TRIM_RST;
			s_reg.cell_gain <= atc_pkg::CELL_TRIM_RST;
			s_reg.aux0_off <= atc_pkg::AUX_OFF_RST;
			s_reg.aux1_off <= atc_pkg::AUX_OFF_RST;
			s_reg.status <= atc_pkg::EVT_RST;
			s_reg.mask <= atc_pkg::EVT_RST;
			s_reg.level <= atc_pkg::EVT_RST;
			s_reg.irq <= 1'b0;
			s_reg.pready <= 1'b0;
			s_reg.pslverr <= 1'b0;
			s_reg.prdata <= 32'h00000000;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irq = s_reg.irq;
endmodule

//--- rtl/atc_pkg.sv
// Package: register map, field layout, reset values and carrier types
package atc_pkg;
	// Bus geometry: one byte location per aligned 32-bit word
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_LOW_LIMIT = 8'hae;
	localparam logic [7:0] IDX_HIGH_LIMIT = 8'hb0;
	localparam logic [7:0] IDX_BATCH_ID = 8'hbe;
	localparam logic [7:0] IDX_SERIAL_ID = 8'hc6;
	localparam logic [7:0] IDX_SCRATCH = 8'hc8;
	localparam logic [7:0] IDX_CELL_OFF = 8'hd2;
	localparam logic [7:0] IDX_CELL_GAIN = 8'hd3;
	localparam logic [7:0] IDX_AUX0_OFF = 8'hd4;
	localparam logic [7:0] IDX_AUX1_OFF = 8'hd6;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;
	localparam logic [7:0] IDX_AUX7_LEVEL = 8'hf2;
	// Byte counts of the eight-byte batch identity and scratch registers
	localparam logic [7:0] BATCH_BYTES = 8'h08;
	localparam logic [7:0] SCRATCH_BYTES = 8'h08;
	// Field layout
	localparam int CODE_W = 16;
	localparam int CHAN_W = 4;
	localparam int LIMIT_LSB = 2;
	localparam int LIMIT_W = 14;
	localparam int CELL_TRIM_W = 8;
	localparam int AUX_OFF_W = 10;
	localparam int TRIM_SHIFT = 16;
	localparam int N_EVT = 2;
	localparam int EVT_OVER = 0;
	localparam int EVT_UNDER = 1;
	// Full code span of the converter in millivolts
	localparam int FULL_SCALE_MV = 5000;
	// Values after reset
	localparam logic [13:0] LOW_LIMIT_RST = 14'h0000;
	localparam logic [13:0] HIGH_LIMIT_RST = 14'h3fff;
	localparam logic [63:0] SCRATCH_RST = 64'h0;
	localparam logic [7:0] CELL_TRIM_RST = 8'h00;
	localparam logic [9:0] AUX_OFF_RST = 10'h000;
	localparam logic [1:0] EVT_RST = 2'h0;
	// One conversion result with its channel tag
	typedef struct packed {
		logic valid;
		logic [CHAN_W-1:0] chan;
		logic [CODE_W-1:0] code;
	} atc_sample_t;
	// Result of one limit check
	typedef struct packed {
		logic valid;
		logic over;
		logic under;
	} atc_limit_evt_t;
	// Whole state of the register bank
	typedef struct packed {
		logic [LIMIT_W-1:0] low_limit;
		logic [LIMIT_W-1:0] high_limit;
		logic [63:0] scratch;
		logic [CELL_TRIM_W-1:0] cell_off;
		logic [CELL_TRIM_W-1:0] cell_gain;
		logic [AUX_OFF_W-1:0] aux0_off;
		logic [AUX_OFF_W-1:0] aux1_off;
		logic [N_EVT-1:0] status;
		logic [N_EVT-1:0] mask;
		logic [N_EVT-1:0] level;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} atc_state_t;
endpackage

//--- rtl/atc_trim.sv
// Gain and offset correction of one stream of conversion results
`timescale 1ns/1ps
module atc_trim #(
	parameter int GAIN_W = 8,
	parameter int OFF_W = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Trim values, two's complement
	input wire logic [GAIN_W-1:0] gain,
	input wire logic [OFF_W-1:0] offset,
	// Raw and corrected results
	input wire atc_pkg::atc_sample_t raw,
	output atc_pkg::atc_sample_t trimmed
);
	atc_pkg::atc_sample_t out_reg;
	atc_pkg::atc_sample_t out_next;
	logic signed [24:0] prod;
	logic signed [18:0] sum;

	// Result plus result times gain over 2^16, plus offset, clamped to the code span
	always_comb begin
		out_next = out_reg;
		prod = $signed({1'b0, raw.code}) * $signed(gain);
		sum = 19'(prod >>> atc_pkg::TRIM_SHIFT)
			+ 19'($signed({1'b0, raw.code}))
			+ 19'($signed(offset));
		out_next.valid = raw.valid;
		if (raw.valid) begin
			out_next.chan = raw.chan;
			if (sum < 0) begin
				out_next.code = '0;
			end else if (sum > 19'sh0ffff) begin
				out_next.code = '1;
			end else begin
				out_next.code = sum[15:0];
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_reg <= '0;
		end else begin
			out_reg <= out_next;
		end
	end

	assign trimmed = out_reg;
endmodule

//--- rtl/atc_limit_cmp.sv
// Window check of auxiliary channel 7 samples
`timescale 1ns/1ps
module atc_limit_cmp (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Limit fields
	input wire logic [13:0] low_limit,
	input wire logic [13:0] high_limit,
	// Sample and verdict
	input wire atc_pkg::atc_sample_t sample,
	output atc_pkg::atc_limit_evt_t verdict
);
	atc_pkg::atc_limit_evt_t evt_reg;
	atc_pkg::atc_limit_evt_t evt_next;

	// Limits sit above two zero bits, so compare on the full code
	always_comb begin
		evt_next.valid = sample.valid;
		evt_next.over = sample.valid
			&& (sample.code > {high_limit, 2'b00});
		evt_next.under = sample.valid
			&& (sample.code < {low_limit, 2'b00});
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			evt_reg <= '0;
		end else begin
			evt_reg <= evt_next;
		end
	end

	assign verdict = evt_reg;
endmodule

//--- test/atc_regs_sva.sv
// Timing checks of the threshold and trim register bank
`timescale 1ns/1ps
module atc_regs_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sample streams
	input wire atc_pkg::atc_sample_t cell_raw,
	input wire atc_pkg::atc_sample_t cell_trimmed,
	input wire atc_pkg::atc_sample_t aux0_raw,
	input wire atc_pkg::atc_sample_t aux0_trimmed,
	input wire atc_pkg::atc_sample_t aux7_raw,
	input wire atc_pkg::atc_limit_evt_t aux7_verdict
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Phases of one transfer
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		psel && penable && pready;
	endsequence
	// Bus answer timing and decode
	AST_ANSWER_NEXT: assert property (
		s_setup |=> s_answer) else $error("no answer after setup");
	AST_ANSWER_ONCE: assert property (
		s_answer |=> !pready) else $error("answer held too long");
	AST_UNMAPPED: assert property (
		s_setup ##0 (paddr[11:10] != 2'h0)
		|=> pslverr && prdata == 32'h0) else $error("unmapped access");
	AST_MAPPED: assert property (
		s_setup ##0 (paddr[11:10] == 2'h0) |=> !pslverr)
		else $error("error on mapped place");
	AST_TOP_ZERO: assert property (
		pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
	// Result latency of the streams
	AST_CELL_NEXT: assert property (
		cell_raw.valid |=> cell_trimmed.valid
		&& cell_trimmed.chan == $past(cell_raw.chan))
		else $error("cell result missing");
	AST_CELL_QUIET: assert property (
		!cell_raw.valid |=> !cell_trimmed.valid)
		else $error("cell result without sample");
	AST_AUX0_NEXT: assert property (
		aux0_raw.valid |=> aux0_trimmed.valid)
		else $error("aux0 result missing");
	AST_VERDICT_NEXT: assert property (
		aux7_raw.valid |=> aux7_verdict.valid) else $error("no verdict");
	AST_VERDICT_QUIET: assert property (
		!aux7_raw.valid |=> !aux7_verdict.valid)
		else $error("verdict without sample");
endmodule

bind atc_regs atc_regs_sva u_sva (.mclk, .rst, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .cell_raw, .cell_trimmed,
	.aux0_raw, .aux0_trimmed, .aux7_raw, .aux7_verdict);

//--- test/test_aux_threshold_calibration_regs.sv
// Self-checking bench of the threshold, identity, scratch and trim bank
`timescale 1ns/1ps
module test_aux_threshold_calibration_regs;
	localparam logic [63:0] LOT = 64'h1122_3344_5566_7788; // Arbitrary
	localparam logic [15:0] SER = 16'h9abc; // Arbitrary
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] cv [4] = '{16'h4001, 16'h4000, 16'h03ff, 16'h0400};
	atc_pkg::atc_sample_t cell_raw, aux0_raw, aux1_raw, aux7_raw;
	atc_pkg::atc_sample_t cell_trimmed, aux0_trimmed, aux1_trimmed;
	atc_pkg::atc_limit_evt_t aux7_verdict;
	int n_fail = 0;
	int checks = 0;
	atc_regs #(.BATCH_ID(LOT), .SERIAL_ID(SER)) dut (.mclk, .rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cell_raw, .aux0_raw, .aux1_raw, .aux7_raw, .cell_trimmed,
		.aux0_trimmed, .aux1_trimmed, .aux7_verdict, .irq);
	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer at word index a
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		// Look at the answer mid-cycle, where it has settled
		do begin
			@(negedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		// The next rising edge completes the access phase
		@(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			test_done();
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(q, {24'h0, x});
	endtask
	// One sample on stream k: 0 cell, 1 aux0, 2 aux1, 3 aux7
	task automatic smp(input int k, input logic [15:0] c);
		atc_pkg::atc_sample_t s;
		s = {1'b1, k[3:0], c};
		@(posedge mclk);
		case (k)
			0: cell_raw <= s;
			1: aux0_raw <= s;
			2: aux1_raw <= s;
			default: aux7_raw <= s;
		endcase
		@(posedge mclk);
		cell_raw <= '0;
		aux0_raw <= '0;
		aux1_raw <= '0;
		aux7_raw <= '0;
		#1;
	endtask
	// Corrected code, clamped to the code span
	function automatic logic [31:0] fix(longint c, longint g, longint o);
		longint v;
		v = c + ((c * g) >>> 16) + o;
		if (v < 0) v = 0;
		if (v > 65535) v = 65535;
		return 32'(v);
	endfunction
	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		test_done();
	end
	initial begin
		{rst, psel, penable, pwrite} = 4'hf;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cell_raw, aux0_raw, aux1_raw, aux7_raw} = '0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(10'h0ae, 8'h00);
		rd(10'h0b1, 8'hfc);
		apb(1'b1, 10'h0ae, 8'h04);
		apb(1'b1, 10'h0af, 8'h03);
		apb(1'b1, 10'h0b0, 8'h40);
		apb(1'b1, 10'h0b1, 8'h00);
		rd(10'h0af, 8'h00);
		rd(10'h0b0, 8'h40);
		$display("test limits done");
		for (int i = 0; i < 4; i++) begin
			smp(3, cv[i]);
			chk(aux7_verdict, {1'b1, cv[i] > 16'h4000, cv[i] < 16'h0400});
		end
		rd(10'h0f2, 8'h00);
		rd(10'h0f0, 8'h03);
		chk(irq, 32'h0);
		apb(1'b1, 10'h0f1, 8'h01);
		rd(10'h0f0, 8'h03);
		chk(irq, 32'h1);
		apb(1'b1, 10'h0f0, 8'h01);
		rd(10'h0f0, 8'h02);
		chk(irq, 32'h0);
		$display("test window done");
		apb(1'b1, 10'h0be, 8'h00);
		for (int i = 0; i < 8; i++) begin
			rd(10'h0be + 10'(i), LOT[63-8*i -: 8]);
			apb(1'b1, 10'h0c8 + 10'(i), 8'h5a ^ 8'(i));
		end
		rd(10'h0c6, SER[15:8]);
		rd(10'h0c7, SER[7:0]);
		apb(1'b1, 10'h3c8, 8'hff);
		chk(e, 32'h1);
		for (int i = 0; i < 8; i++) begin
			rd(10'h0c8 + 10'(i), 8'h5a ^ 8'(i));
		end
		$display("test ids and store done");
		apb(1'b1, 10'h0d4, 8'hfe);
		rd(10'h0d4, 8'h02);
		apb(1'b1, 10'h0d7, 8'h05);
		smp(1, 16'h1000);
		chk(aux0_trimmed.code, fix(4096, 0, -512));
		smp(1, 16'h0100);
		chk(aux0_trimmed.code, 32'h0);
		smp(2, 16'hfffd);
		chk(aux1_trimmed.code, 32'hffff);
		apb(1'b1, 10'h0d2, 8'hfe);
		apb(1'b1, 10'h0d3, 8'h7f);
		rd(10'h0d3, 8'h7f);
		smp(0, 16'h8000);
		chk(cell_trimmed.code, fix(32768, 127, -2));
		apb(1'b1, 10'h0d3, 8'h80);
		smp(0, 16'h8000);
		chk(cell_trimmed.code, fix(32768, -128, -2));
		smp(0, 16'h0001);
		chk(cell_trimmed.code, 32'h0);
		$display("test trims done");
		test_done();
	end
endmodule
